// ===== bench/host_model.sv
// Host processor model: drives the register port and collects results.
// Assumes the block takes requests on the rising core clock edge.
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input wire logic core_clk, // Core clock
  input wire logic data_avail_n, // Data-available pin
  input wire logic [15:0] regRdata, // Read data
  output logic regWrite, // Write strobe
  output logic regRead, // Read strobe
  output logic [9:0] regAddr, // Register address
  output logic [15:0] regWdata, // Write data
  output logic resultRead // Result read pulse
);
  // Quiet port at time zero
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 10'h3ff;
    regWdata = 16'hffff;
    resultRead = 1'b0;
  end

  // One write; data is scrambled once taken so stale values never look valid
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(negedge core_clk);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge core_clk);
    regWrite = 1'b0;
    regWdata = ~d;
  endtask : wr

  // One read; data is taken in the cycle after the strobe
  task automatic rd(input logic [9:0] a, output logic [15:0] d);
    @(negedge core_clk);
    regAddr = a;
    regRead = 1'b1;
    @(negedge core_clk);
    regRead = 1'b0;
    d = regRdata;
  endtask : rd

  // read only while pin low, then clear flag
  task automatic take(output logic ok);
    ok = 1'b0;
    repeat (200) begin
      @(negedge core_clk);
      if (data_avail_n === 1'b0) begin
        ok = 1'b1;
        break;
      end
    end
    if (ok) begin
      resultRead = 1'b1;
      @(negedge core_clk);
      resultRead = 1'b0;
      wr(touch_ctrl_pkg::READ_CLR_ADDR, 16'h0000);
    end
  endtask : take
endmodule : host_model
`default_nettype wire

// ===== bench/touch_adc_power_irq_ctrl_tb.sv
// Self-checking bench for the touch converter control block.
// Assumes the host model owns the register port; bench drives pins on falling edges.
`timescale 1ns/10ps
`default_nettype none
module touch_adc_power_irq_ctrl_tb;
  logic core_clk, reset_n, regWrite, regRead, resultRead, penDisable, timerExpire; // Stimulus
  logic touchPin, alertPin, data_avail_n, touch_irq_n, convDone, softReset; // Pins
  logic adcPower, biasPower, oscPower, sensorPower; // Power levels
  logic [9:0] regAddr; // Address
  logic [15:0] regWdata, regRdata, rv; // Data words
  logic [1:0] convMode; // Converter mode
  logic [5:0] limitHit; // Limit flags
  logic [6:0] convChannels; // Channel set
  logic ok; // Handshake seen
  int n_mismatch, checks_done, cnt; // Counters

  // Short delay steps keep the run brief
  touch_adc_power_irq_ctrl #(.STEP_CYC(4), .CONV_CYC(16)) u_touch_adc_power_irq_ctrl (
    .core_clk(core_clk), .reset_n(reset_n), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .resultRead(resultRead), .convMode(convMode),
    .penDisable(penDisable), .timerExpire(timerExpire), .touchPin(touchPin), .alertPin(alertPin),
    .limitHit(limitHit), .regRdata(regRdata), .data_avail_n(data_avail_n), .touch_irq_n(touch_irq_n),
    .adcPower(adcPower), .biasPower(biasPower), .oscPower(oscPower), .sensorPower(sensorPower),
    .convChannels(convChannels), .convDone(convDone), .softReset(softReset));
  host_model u_host_model (
    .core_clk(core_clk), .data_avail_n(data_avail_n), .regRdata(regRdata), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .resultRead(resultRead));

  // Clock generator, 100 MHz
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Compare one value, report at once
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick

  // Bounded wait for sequence end; cnt holds cycles spent
  task automatic wait_done();
    for (cnt = 1; cnt < 400; cnt++) begin
      @(negedge core_clk);
      if (convDone === 1'b1) break;
    end
  endtask : wait_done

  task automatic t_reset();
    u_host_model.rd(10'h002, rv);
    chk(rv, 16'h4040);
    u_host_model.rd(10'h003, rv);
    chk(rv, 16'h0000);
    u_host_model.rd(10'h055, rv);
    chk(rv, 16'h0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_seq();
    u_host_model.wr(10'h002, 16'h8041);
    u_host_model.wr(10'h003, 16'h0018);
    convMode = 2'h2;
    tick(1);
    convMode = 2'h0;
    chk({15'h0, data_avail_n}, 16'h1);
    wait_done();
    chk({15'h0, cnt >= 48 && cnt < 60}, 16'h1);
    chk({9'h0, convChannels}, 16'h000c);
    tick(2);
    chk({15'h0, data_avail_n}, 16'h0);
    convMode = 2'h2;
    timerExpire = 1'b1;
    tick(1);
    timerExpire = 1'b0;
    convMode = 2'h0;
    tick(2);
    chk({15'h0, data_avail_n}, 16'h1);
    wait_done();
    u_host_model.take(ok);
    tick(2);
    chk({15'h0, ok & data_avail_n}, 16'h1);
    convMode = 2'h1;
    tick(1);
    convMode = 2'h0;
    wait_done();
    chk({9'h0, convChannels}, 16'h0004);
    u_host_model.take(ok);
    chk({15'h0, ok}, 16'h1);
    $display("test sequence done");
  endtask : t_seq

  task automatic t_power();
    chk({13'h0, adcPower, biasPower, oscPower}, 16'h0007);
    u_host_model.wr(10'h002, 16'h4040);
    convMode = 2'h3;
    tick(3);
    chk({12'h0, adcPower, biasPower, oscPower, sensorPower}, 16'h0000);
    u_host_model.wr(10'h002, 16'h8040);
    convMode = 2'h2;
    tick(8);
    convMode = 2'h0;
    u_host_model.wr(10'h002, 16'h0040);
    tick(2);
    chk({12'h0, adcPower, biasPower, oscPower, sensorPower}, 16'h0000);
    wait_done();
    chk({15'h0, cnt == 400}, 16'h1);
    u_host_model.wr(10'h002, 16'h8050);
    cnt = 0;
    repeat (3) begin
      if (softReset === 1'b1) cnt++;
      tick(1);
    end
    chk(cnt[15:0], 16'h0001);
    u_host_model.rd(10'h002, rv);
    chk(rv & 16'h0010, 16'h0000);
    u_host_model.wr(10'h002, 16'h8040);
    $display("test power done");
  endtask : t_power

  task automatic t_irq();
    u_host_model.wr(10'h003, 16'h2000);
    limitHit = 6'h04;
    tick(6);
    chk({15'h0, data_avail_n}, 16'h0);
    u_host_model.rd(10'h003, rv);
    chk(rv, 16'h2100);
    u_host_model.wr(10'h003, 16'ha000);
    tick(4);
    chk({15'h0, data_avail_n}, 16'h1);
    limitHit = 6'h00;
    u_host_model.wr(10'h003, 16'h1000);
    alertPin = 1'b1;
    tick(6);
    chk({15'h0, data_avail_n}, 16'h0);
    alertPin = 1'b0;
    tick(6);
    chk({15'h0, data_avail_n}, 16'h1);
    u_host_model.wr(10'h003, 16'h0002);
    $display("test interrupt done");
  endtask : t_irq

  task automatic t_pen();
    penDisable = 1'b1;
    convMode = 2'h3;
    touchPin = 1'b1;
    tick(8);
    chk({15'h0, touch_irq_n}, 16'h1);
    touchPin = 1'b0;
    wait_done();
    u_host_model.take(ok);
    penDisable = 1'b0;
    touchPin = 1'b1;
    tick(6);
    chk({15'h0, touch_irq_n}, 16'h0);
    touchPin = 1'b0;
    tick(6);
    chk({15'h0, touch_irq_n}, 16'h0);
    wait_done();
    tick(6);
    chk({15'h0, touch_irq_n}, 16'h1);
    u_host_model.take(ok);
    convMode = 2'h0;
    $display("test pen done");
  endtask : t_pen

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  // Main sequence after a four-cycle reset
  initial begin
    n_mismatch = 0;
    checks_done = 0;
    reset_n = 1'b0;
    convMode = 2'h0;
    penDisable = 1'b0;
    timerExpire = 1'b0;
    touchPin = 1'b0;
    alertPin = 1'b0;
    limitHit = 6'h00;
    tick(4);
    reset_n = 1'b1;
    t_reset();
    t_seq();
    t_power();
    t_irq();
    t_pen();
    test_done();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #400000;
    n_mismatch++;
    test_done();
  end
endmodule : touch_adc_power_irq_ctrl_tb
`default_nettype wire

// ===== design/delay_timer.sv
// Counter for the programmable settling delay, in 128 us steps.
// Assumes start is a one-cycle pulse from the control state machine.
`timescale 1ns/10ps
`default_nettype none
module delay_timer #(
  parameter int STEP_CYC = touch_ctrl_pkg::DELAY_STEP_CYC
) (
  input wire logic core_clk, // Core clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic start, // Begin a delay
  input wire logic abort, // Drop a running delay
  input wire logic [3:0] code, // Delay code
  output logic done // One-cycle pulse at delay end
);
  typedef struct packed {
    logic [13:0] stepCnt; // Cycles within a step
    logic [5:0] steps; // Steps left
    logic busy; // Delay running
    logic done; // Done pulse
  } state_s;
  state_s st_q;
  state_s st_d;
  logic [5:0] stepsFor; // Step count for the code

  always_comb begin
    if (code <= 4'h9) begin
      stepsFor = {2'h0, code} + 6'h01;
    end else begin
      case (code)
        4'ha: stepsFor = 6'd12;
        4'hb: stepsFor = 6'd14;
        4'hc: stepsFor = 6'd16;
        4'hd: stepsFor = 6'd20;
        4'he: stepsFor = 6'd28;
        default: stepsFor = 6'd32;
      endcase
    end
  end

  // Next state: steps count down, each step STEP_CYC cycles
  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    if (abort) begin
      st_d.busy = 1'b0;
    end else if (start) begin
      st_d.busy = 1'b1;
      st_d.steps = stepsFor;
      st_d.stepCnt = '0;
    end else if (st_q.busy) begin
      if (st_q.stepCnt == 14'(STEP_CYC - 1)) begin
        st_d.stepCnt = '0;
        st_d.steps = st_q.steps - 6'h01;
        if (st_q.steps == 6'h01) begin
          st_d.busy = 1'b0;
          st_d.done = 1'b1;
        end
      end else begin
        st_d.stepCnt = st_q.stepCnt + 14'h0001;
      end
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign done = st_q.done;
endmodule : delay_timer
`default_nettype wire

// ===== design/touch_adc_power_irq_ctrl.sv
// Control and interrupt logic of a touch screen converter.
// Assumes registers written and read over a decoded register port from the serial
// front end; converter mode, pen disable and timer events come from the first control
// register logic; touch, alert and limit inputs are asynchronous pins or analog flags.
`timescale 1ns/10ps
`default_nettype none
module touch_adc_power_irq_ctrl #(
  parameter int STEP_CYC = touch_ctrl_pkg::DELAY_STEP_CYC, // Cycles per delay step
  parameter int CONV_CYC = 16 // Cycles per channel conversion
) (
  input wire logic core_clk, // Core clock, 100 MHz
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic regWrite, // Register write strobe
  input wire logic regRead, // Register read strobe
  input wire logic [9:0] regAddr, // Register address
  input wire logic [15:0] regWdata, // Write data
  input wire logic resultRead, // Result register read pulse
  input wire logic [1:0] convMode, // Converter mode field
  input wire logic penDisable, // Pen output disable bit
  input wire logic timerExpire, // Repeat timer event pulse
  input wire logic touchPin, // Screen touched, async
  input wire logic alertPin, // General-purpose pin event, async
  input wire logic [5:0] limitHit, // Limit flags, async: auxb lo/hi, temp lo/hi, spare
  output logic [15:0] regRdata, // Read data
  output logic data_avail_n, // Interrupt pin, active low
  output logic touch_irq_n, // Pen output, active low
  output logic adcPower, // Converter powered
  output logic biasPower, // Bias powered
  output logic oscPower, // Oscillator powered
  output logic sensorPower, // Temperature sensor powered
  output logic [6:0] convChannels, // Channels converted this sequence
  output logic convDone, // Sequence finished pulse
  output logic softReset // Device soft reset pulse
);
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001, // Waiting for trigger
    S_DELAY = 5'b00010, // Settling delay
    S_CONV = 5'b00100, // Converting a channel
    S_POST = 5'b01000, // Precharge delay after sequence
    S_OFF = 5'b10000 // Full shutdown
  } conv_state_e;

  typedef struct packed {
    logic [15:0] pwrCtrl; // Power, filter and delay register
    logic [15:0] irqSeq; // Interrupt and sequence register
    conv_state_e fsm; // Conversion sequencer
    logic [6:0] pending; // Channels left
    logic [6:0] active; // Channels of this sequence
    logic [7:0] convCnt; // Cycles in conversion
    logic readFlag; // Results read since last clear
    logic avail; // New data held
    logic penLow; // Pen output asserted
    logic [2:0] touchSync; // Touch synchroniser
    logic [2:0] alertSync; // Alert synchroniser
    logic [11:0] limitSync; // Limit synchronisers, two stages of six
    logic [5:0] limitLast; // Third stage
    logic intPin; // Registered pin value, active low
    logic [15:0] rdata; // Read data
    logic done; // Sequence end pulse
    logic swRst; // Soft reset pulse
    logic adcPow; // Converter power
    logic biasPow; // Bias power
    logic oscPow; // Oscillator power
    logic sensPow; // Temperature sensor power
  } state_s;

  state_s st_q;
  state_s st_d;
  logic delayStart; // Start settling delay
  logic delayDone; // Delay finished
  logic delayAbort; // Drop delay
  logic touched; // Filtered touch level
  logic alertLvl; // Filtered alert level
  logic [5:0] limitLvl; // Filtered limit levels
  logic [1:0] pwrLvl; // Current power level
  logic busy; // Converter active
  logic [6:0] firstSel; // Lowest pending channel, one-hot
  logic alarmAny; // Unmasked alarm
  logic [6:0] seqSel; // Sequence field
  logic [6:0] singleSel; // Lowest selected channel for single mode, one-hot

  // Settling delay counter
  delay_timer #(.STEP_CYC(STEP_CYC)) delayUnit (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .start(delayStart),
    .abort(delayAbort),
    .code(st_q.pwrCtrl[touch_ctrl_pkg::DELAY_POS +: 4]),
    .done(delayDone)
  );

  // A rise counts once the second and third stages agree; a fall counts as soon as the second stage drops
  assign touched = st_q.touchSync[2] & st_q.touchSync[1];
  assign alertLvl = st_q.alertSync[2] & st_q.alertSync[1];
  assign limitLvl = st_q.limitLast & st_q.limitSync[11:6];
  assign pwrLvl = st_q.pwrCtrl[touch_ctrl_pkg::PWR_LVL_POS +: 2];
  assign busy = (st_q.fsm != S_IDLE) && (st_q.fsm != S_OFF);
  // bit 7 Y position down to bit 1 temperature
  assign seqSel = st_q.irqSeq[7:1];
  assign firstSel = st_q.pending & (~st_q.pending + 7'h01);
  assign singleSel = seqSel & (~seqSel + 7'h01);

  // masked limit sources; temp mask bit 15, aux/battery mask unused bit 0
  assign alarmAny = (~st_q.irqSeq[touch_ctrl_pkg::TEMP_MASK_POS] &
                     (st_q.irqSeq[touch_ctrl_pkg::TEMP_LOW_POS] | st_q.irqSeq[touch_ctrl_pkg::TEMP_HIGH_POS]))
                  | (st_q.irqSeq[touch_ctrl_pkg::AUXB_LOW_POS] | st_q.irqSeq[touch_ctrl_pkg::AUXB_HIGH_POS]);

  // Next-state logic
  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    st_d.swRst = 1'b0;
    delayStart = 1'b0;
    delayAbort = 1'b0;
    st_d.touchSync = {st_q.touchSync[1:0], touchPin};
    st_d.alertSync = {st_q.alertSync[1:0], alertPin};
    st_d.limitSync = {st_q.limitSync[5:0], limitHit};
    st_d.limitLast = st_q.limitSync[11:6];
    st_d.rdata = 16'h0000;

    // Register writes
    if (regWrite) begin
      case (regAddr)
        touch_ctrl_pkg::PWR_CTRL_ADDR: begin
          // soft reset bit is a self-clearing action
          st_d.pwrCtrl = regWdata;
          st_d.pwrCtrl[touch_ctrl_pkg::SOFT_RST_POS] = 1'b0;
          st_d.swRst = regWdata[touch_ctrl_pkg::SOFT_RST_POS];
        end
        touch_ctrl_pkg::IRQ_SEQ_ADDR: begin
          // upper interrupt byte, lower sequence byte
          st_d.irqSeq = regWdata;
        end
        touch_ctrl_pkg::READ_CLR_ADDR: begin
          if (regWdata == 16'h0000) begin
            st_d.readFlag = 1'b0;
          end
        end
        default: begin
          // Unmapped writes are ignored
        end
      endcase
    end

    // Register reads
    if (regRead) begin
      case (regAddr)
        touch_ctrl_pkg::PWR_CTRL_ADDR: st_d.rdata = st_q.pwrCtrl;
        touch_ctrl_pkg::IRQ_SEQ_ADDR: st_d.rdata = st_q.irqSeq;
        default: st_d.rdata = 16'h0000;
      endcase
    end

    // sticky limit status; set wins over a clearing write
    if (limitLvl[5]) st_d.irqSeq[touch_ctrl_pkg::AUXB_LOW_POS] = 1'b1;
    if (limitLvl[4]) st_d.irqSeq[touch_ctrl_pkg::AUXB_HIGH_POS] = 1'b1;
    if (limitLvl[3]) st_d.irqSeq[touch_ctrl_pkg::TEMP_LOW_POS] = 1'b1;
    if (limitLvl[2]) st_d.irqSeq[touch_ctrl_pkg::TEMP_HIGH_POS] = 1'b1;

    if (resultRead) begin
      st_d.readFlag = 1'b1;
      st_d.avail = 1'b0;
    end

    // Sequencer
    case (st_q.fsm)
      S_IDLE: begin
        // mode 11 waits for touch, 01/10 start on host mode
        if ((convMode == touch_ctrl_pkg::MODE_TOUCH && touched) ||
            convMode == touch_ctrl_pkg::MODE_SEQ || convMode == touch_ctrl_pkg::MODE_SINGLE ||
            (timerExpire && convMode != touch_ctrl_pkg::MODE_IDLE)) begin
          // only selected channels; single mode uses the lowest selected
          st_d.pending = (convMode == touch_ctrl_pkg::MODE_SINGLE) ? singleSel : seqSel;
          st_d.active = st_d.pending;
          if (timerExpire) st_d.avail = 1'b0;
          delayStart = 1'b1;
          st_d.fsm = S_DELAY;
        end
      end
      S_DELAY: begin
        if (delayDone) begin
          st_d.convCnt = '0;
          st_d.fsm = S_CONV;
        end
      end
      S_CONV: begin
        if (st_q.pending == 7'h00) begin
          // precharge delay after the last conversion
          delayStart = 1'b1;
          st_d.fsm = S_POST;
        end else if (st_q.convCnt == 8'(CONV_CYC - 1)) begin
          st_d.convCnt = '0;
          st_d.pending = st_q.pending & ~firstSel;
          // delay again before an X or Y channel
          if (|(st_d.pending & touch_ctrl_pkg::XY_CHANNELS & ~(st_d.pending - 7'h01) & st_d.pending)) begin
            delayStart = 1'b1;
            st_d.fsm = S_DELAY;
          end
        end else begin
          st_d.convCnt = st_q.convCnt + 8'h01;
        end
      end
      S_POST: begin
        if (delayDone) begin
          st_d.avail = 1'b1;
          st_d.done = 1'b1;
          st_d.fsm = S_IDLE;
        end
      end
      S_OFF: begin
        if (pwrLvl != touch_ctrl_pkg::PWR_OFF) st_d.fsm = S_IDLE;
      end
      default: st_d.fsm = S_IDLE;
    endcase

    // full shutdown overrides modes and aborts at once
    if (st_d.pwrCtrl[touch_ctrl_pkg::PWR_LVL_POS +: 2] == touch_ctrl_pkg::PWR_OFF) begin
      st_d.fsm = S_OFF;
      st_d.pending = '0;
      delayAbort = 1'b1;
      delayStart = 1'b0;
    end

    // pen output; released on touch end only when idle
    if (penDisable || convMode != touch_ctrl_pkg::MODE_TOUCH) begin
      st_d.penLow = 1'b0;
    end else if (touched && !busy) begin
      st_d.penLow = 1'b1;
    end else if (!touched && !busy) begin
      st_d.penLow = 1'b0;
    end

    if (st_q.irqSeq[touch_ctrl_pkg::ALERT_POS]) begin
      st_d.intPin = ~alertLvl;
    end else if (st_q.irqSeq[touch_ctrl_pkg::OUT_SEL_POS]) begin
      st_d.intPin = ~alarmAny;
    end else begin
      // low only while new data is held
      st_d.intPin = ~st_d.avail;
    end

    // Power outputs: level 10 converter, bias, oscillator on and sensor while busy, 01/11 by mode, 00 off
    if (pwrLvl == touch_ctrl_pkg::PWR_OFF) begin
      st_d.adcPow = 1'b0;
      st_d.biasPow = 1'b0;
      st_d.oscPow = 1'b0;
      st_d.sensPow = 1'b0;
    end else if (pwrLvl == touch_ctrl_pkg::PWR_ON) begin
      st_d.adcPow = 1'b1;
      st_d.biasPow = 1'b1;
      st_d.oscPow = 1'b1;
      st_d.sensPow = busy;
    end else begin
      // touch mode sleeps fully until touch; host modes keep timing on
      st_d.adcPow = busy;
      st_d.sensPow = busy;
      st_d.biasPow = busy || convMode != touch_ctrl_pkg::MODE_TOUCH;
      st_d.oscPow = busy || convMode != touch_ctrl_pkg::MODE_TOUCH;
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
      st_q.pwrCtrl <= touch_ctrl_pkg::PWR_CTRL_RESET;
      st_q.irqSeq <= touch_ctrl_pkg::IRQ_SEQ_RESET;
      st_q.fsm <= S_IDLE;
      st_q.intPin <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign regRdata = st_q.rdata;
  assign data_avail_n = st_q.intPin;
  assign touch_irq_n = ~st_q.penLow;
  assign adcPower = st_q.adcPow;
  assign biasPower = st_q.biasPow;
  assign oscPower = st_q.oscPow;
  assign sensorPower = st_q.sensPow;
  assign convChannels = st_q.active;
  assign convDone = st_q.done;
  assign softReset = st_q.swRst;

  // Assertions
  a_shutdown_powers: assert property (@(posedge core_clk) disable iff (!reset_n)
    (pwrLvl == touch_ctrl_pkg::PWR_OFF) |=> !adcPower && !oscPower && !biasPower)
    else $error("power not off in shutdown");
  a_level_on: assert property (@(posedge core_clk) disable iff (!reset_n)
    (pwrLvl == touch_ctrl_pkg::PWR_ON) |=> adcPower && biasPower && oscPower)
    else $error("power level on not honoured");
  a_avail_low: assert property (@(posedge core_clk) disable iff (!reset_n)
    convDone && !st_q.irqSeq[touch_ctrl_pkg::OUT_SEL_POS] && !st_q.irqSeq[touch_ctrl_pkg::ALERT_POS]
    && !resultRead |-> !data_avail_n)
    else $error("indicator not low at sequence end");
  a_read_release: assert property (@(posedge core_clk) disable iff (!reset_n)
    resultRead |=> !st_q.avail)
    else $error("result read did not release");
  a_flag_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
    regWrite && regAddr == touch_ctrl_pkg::READ_CLR_ADDR && regWdata == 16'h0000 && !resultRead
    |=> !st_q.readFlag)
    else $error("read flag not cleared");
  a_pen_disabled: assert property (@(posedge core_clk) disable iff (!reset_n)
    penDisable |=> touch_irq_n)
    else $error("pen output active while disabled");
  a_pen_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    !touch_irq_n && busy && !penDisable && convMode == touch_ctrl_pkg::MODE_TOUCH |=> !touch_irq_n)
    else $error("pen output released during conversion");
  a_soft_reset: assert property (@(posedge core_clk) disable iff (!reset_n)
    regWrite && regAddr == touch_ctrl_pkg::PWR_CTRL_ADDR && regWdata[touch_ctrl_pkg::SOFT_RST_POS]
    |=> softReset)
    else $error("soft reset not issued");
  a_off_state: assert property (@(posedge core_clk) disable iff (!reset_n)
    regWrite && regAddr == touch_ctrl_pkg::PWR_CTRL_ADDR && regWdata[15:14] == touch_ctrl_pkg::PWR_OFF
    |=> st_q.fsm == S_OFF)
    else $error("shutdown not immediate");
  c_sequence: cover property (@(posedge core_clk) disable iff (!reset_n) convDone);
  c_pen: cover property (@(posedge core_clk) disable iff (!reset_n) !touch_irq_n);
  c_alarm: cover property (@(posedge core_clk) disable iff (!reset_n)
    st_q.irqSeq[touch_ctrl_pkg::OUT_SEL_POS] && !data_avail_n);
endmodule : touch_adc_power_irq_ctrl
`default_nettype wire

// ===== design/touch_ctrl_pkg.sv
// Package of constants for the touch converter control and interrupt block.
// Assumes a 100 MHz core clock and a register port of address, data and write/read strobes.
// Overview of operation
// - Programmable delay before first conversion, sixteen codes
// - Same delay before X/Y and after sequence
// - Power level zero shuts everything, ignores mode
// - Levels 01/11 sleep per converter mode
// - Level 10 keeps converter, bias, oscillator on
// - Second control register resets to 0x4040
// - Soft reset bit resets the device
// - Third register: interrupt high, sequence low
// - Sequenced modes convert only selected channels
// - Output select picks data-available or alarm
// - Data-available goes low when results stored
// - Result read or timer restart releases indicator
// - Zero write to 0x81 clears read flag
// - Alarm mode: any unmasked source drives low
// - Separate high and low limit status bits
// - Mask bit 15 silences the temperature source only
// - Pen output low on touch in mode 11 unless disabled
// - Pen detection idles high, off while converting
// - Touch end releases pen output when idle
// - Alert bit routes general-purpose pin interrupt
// - Mode 11 touch-triggered, 01/10 host-triggered
package touch_ctrl_pkg;
  localparam logic [9:0] PWR_CTRL_ADDR = 10'h002; // Power, filter and delay control
  localparam logic [9:0] IRQ_SEQ_ADDR = 10'h003; // Interrupt and sequence control
  localparam logic [9:0] READ_CLR_ADDR = 10'h081; // Read flag clear
  localparam logic [15:0] PWR_CTRL_RESET = 16'h4040; // Power-on value
  localparam logic [15:0] IRQ_SEQ_RESET = 16'h0000; // Power-on value
  localparam int PWR_LVL_POS = 14; // Power level field, two bits
  localparam int SOFT_RST_POS = 4; // Soft reset bit
  localparam int DELAY_POS = 0; // First conversion delay field, four bits
  localparam int OUT_SEL_POS = 13; // Interrupt output select
  localparam int ALERT_POS = 12; // General-purpose alert enable
  localparam int TEMP_MASK_POS = 15; // Temperature source mask
  localparam int AUXB_LOW_POS = 11; // Aux/battery low status
  localparam int AUXB_HIGH_POS = 10; // Aux/battery high status
  localparam int TEMP_LOW_POS = 9; // Temperature low status
  localparam int TEMP_HIGH_POS = 8; // Temperature high status
  localparam int CLK_MHZ = 100; // Core clock rate
  localparam int DELAY_STEP_US = 128; // Delay step in microseconds
  localparam int DELAY_STEP_CYC = DELAY_STEP_US * CLK_MHZ; // Cycles per step
  localparam logic [1:0] PWR_OFF = 2'h0; // Full shutdown
  localparam logic [1:0] PWR_ON = 2'h2; // Always on
  localparam logic [1:0] MODE_IDLE = 2'h0; // No conversion
  localparam logic [1:0] MODE_SINGLE = 2'h1; // Host-triggered single channel
  localparam logic [1:0] MODE_SEQ = 2'h2; // Host-triggered sequence
  localparam logic [1:0] MODE_TOUCH = 2'h3; // Touch-triggered sequence
  localparam logic [6:0] XY_CHANNELS = 7'h60; // Y and X position bits of sequence field
endpackage : touch_ctrl_pkg
